// ---- common/cio_pkg.sv ----
// shared constants of the io network manager: offsets, codes, status layout, timing
// assumes a single 40 MHz system clock and a 32-bit ahb-lite register bus
package cio_pkg;

	// ***************************************************
	// timing
	// ***************************************************
	localparam int unsigned CLK_HZ          = 40_000_000;
	localparam int unsigned MS_PER_S        = 1000;
	localparam int unsigned PDO_STEP_MS     = 1;
	localparam int unsigned PDO_STEP_CYCLES = CLK_HZ / MS_PER_S * PDO_STEP_MS;
	localparam int unsigned PDO_PERIOD_W    = 16;
	localparam logic [15:0] PDO_PERIOD_RST  = 16'h0005;
	localparam logic [15:0] PDO_PERIOD_MIN  = 16'h0001;

	// ***************************************************
	// protocol select codes
	// ***************************************************
	localparam logic [7:0] SEL_PROP       = 8'h20;
	localparam logic [7:0] SEL_FIELDBUS   = 8'h21;
	localparam logic [7:0] SEL_USER_LO    = 8'h22;
	localparam logic [7:0] SEL_USER_HI    = 8'h27;
	localparam logic [7:0] SEL_COPEN_LO   = 8'h28;
	localparam logic [7:0] SEL_COPEN_HI   = 8'h2a;

	// ***************************************************
	// addressing mode and module limits
	// ***************************************************
	localparam logic       AMODE_SHARED     = 1'b0;
	localparam logic       AMODE_COMPAT     = 1'b1;
	localparam logic [5:0] MOD_LIMIT_SHARED = 6'h20;
	localparam logic [5:0] MOD_LIMIT_COMPAT = 6'h10;
	localparam int unsigned MODULES         = 16;
	localparam int unsigned GROUP           = 4;

	typedef enum logic [1:0] {
		CIO_CAN_OFF   = 2'h0,
		CIO_CAN_CMD   = 2'h1,
		CIO_CAN_IO    = 2'h2,
		CIO_CAN_COPEN = 2'h3
	} cio_can_mode_t;

	typedef enum logic [1:0] {
		RI_IDLE  = 2'b00,
		RI_START = 2'b01,
		RI_WAIT  = 2'b11
	} cio_ri_state_t;

	// ***************************************************
	// register byte offsets
	// ***************************************************
	localparam logic [7:0] REG_SEL      = 8'h00;
	localparam logic [7:0] REG_ENABLE   = 8'h04;
	localparam logic [7:0] REG_AMODE    = 8'h08;
	localparam logic [7:0] REG_STATUS   = 8'h0c;
	localparam logic [7:0] REG_PDO      = 8'h10;
	localparam logic [7:0] REG_CANMODE  = 8'h14;
	localparam logic [7:0] REG_IRQ_STAT = 8'h18;
	localparam logic [7:0] REG_IRQ_CLR  = 8'h1c;
	localparam logic [7:0] REG_IRQ_EN   = 8'h20;

	// ***************************************************
	// status word and interrupt layout
	// ***************************************************
	localparam int unsigned ST_W         = 15;
	localparam int unsigned ST_REINIT    = 4;
	localparam int unsigned ST_INIT_DONE = 5;
	localparam int unsigned ST_ANALOG    = 6;
	localparam int unsigned ST_OUT_LO    = 7;
	localparam int unsigned ST_IN_LO     = 11;
	localparam int unsigned IRQ_W        = 3;
	localparam int unsigned IRQ_INIT     = 0;
	localparam int unsigned IRQ_MOD_ERR  = 1;
	localparam int unsigned IRQ_ANALOG   = 2;

	localparam logic HRESP_OKAY = 1'b0;

endpackage : cio_pkg

// ---- verilog/cio_sticky_flags.sv ----
// sticky flag bank: bits set by events, cleared by a clear vector
// assumes set and clear are synchronous to clk_sys
module cio_sticky_flags #(
	parameter int unsigned W = 8
) (
	// clock and reset
	input  wire logic         clk_sys,
	input  wire logic         resetn,
	// event and clear vectors
	input  wire logic [W-1:0] set,
	input  wire logic [W-1:0] clr,
	// held flags
	output logic      [W-1:0] flags
);

	// set wins so an event in the clearing cycle is kept
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			flags <= '0;
		else
			flags <= (flags & ~clr) | set;
	end

endmodule : cio_sticky_flags

// ---- verilog/cio_pdo_timer.sv ----
// pdo cycle timer: a millisecond step divider and a period counter in steps
// assumes period is at least one; counters restart whenever run drops
module cio_pdo_timer #(
	parameter int unsigned STEP_CYCLES = cio_pkg::PDO_STEP_CYCLES,
	parameter int unsigned PW          = cio_pkg::PDO_PERIOD_W
) (
	// clock and reset
	input  wire logic          clk_sys,
	input  wire logic          resetn,
	// control
	input  wire logic          run,
	input  wire logic [PW-1:0] period,
	// one-cycle pulse per pdo cycle
	output logic               tick
);

	localparam int unsigned SW = (STEP_CYCLES > 1) ? $clog2(STEP_CYCLES) : 1;
	localparam logic [SW-1:0] STEP_LAST = SW'(STEP_CYCLES - 1);

	logic [SW-1:0] step_cnt;
	logic [PW-1:0] ms_cnt;
	logic          step_tick;

	assign step_tick = (step_cnt == STEP_LAST);

	// millisecond enable divider
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			step_cnt <= '0;
		else if (!run || step_tick)
			step_cnt <= '0;
		else
			step_cnt <= step_cnt + 1'b1;
	end

	// period count in whole milliseconds
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			ms_cnt <= '0;
			tick   <= 1'b0;
		end
		else
		begin
			tick <= 1'b0;
			if (!run)
				ms_cnt <= '0;
			else if (step_tick)
			begin
				// compare before increment so a shortened period takes effect at once
				if (ms_cnt + 1'b1 >= period)
				begin
					ms_cnt <= '0;
					tick   <= 1'b1;
				end
				else
					ms_cnt <= ms_cnt + 1'b1;
			end
		end
	end

endmodule : cio_pdo_timer

// ---- verilog/cio_net_manager.sv ----
// can io network manager: protocol select, enable, addressing mode, status word, pdo timing
// assumes an ahb-lite master on clk_sys and a network engine that reports module errors
//
// Decided for this implementation: the AHB-Lite register port and the placing of the registers.
module cio_net_manager #(
	parameter int unsigned PDO_STEP_CYCLES = cio_pkg::PDO_STEP_CYCLES
) (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	// nonvolatile store
	input  wire logic        nv_load,
	input  wire logic [7:0]  nv_protocol_select,
	input  wire logic        nv_addressing_mode,
	output logic             nv_save,
	output logic      [7:0]  fieldbus_protocol_select,
	output logic             module_addressing_mode,
	// network engine control
	output logic             prop_io_link_en,
	output logic             fieldbus_en,
	output logic             user_proto_en,
	output logic             canopen_en,
	output logic      [1:0]  canopen_map,
	output logic             module_overlap_ok,
	output logic      [5:0]  module_limit,
	output logic             net_reinit,
	output logic             pdo_tx_tick,
	// network engine reports
	input  wire logic        init_done_in,
	input  wire logic [15:0] module_err,
	input  wire logic [15:0] out_module_err,
	input  wire logic [15:0] in_module_err,
	input  wire logic        analog_err,
	// interrupt
	output logic             irq
);

	// ***************************************************
	// declarations
	// ***************************************************
	logic                      fieldbus_protocol_enable;
	logic [15:0]               pdo_cycle_period;
	cio_pkg::cio_can_mode_t    can_mode;
	cio_pkg::cio_ri_state_t    ri_state;
	logic                      reinit_req;
	logic                      init_complete;
	logic                      wr_pend;
	logic [7:0]                wr_addr;
	logic                      rd_pend;
	logic [7:0]                rd_addr;
	logic [31:0]               next_rdata;
	logic                      accept;
	logic                      link_up;
	logic [cio_pkg::ST_W-1:0]  err_set;
	logic [cio_pkg::ST_W-1:0]  err_flags;
	logic [cio_pkg::ST_W-1:0]  err_clr;
	logic [cio_pkg::ST_W-1:0]  status_word;
	logic [cio_pkg::IRQ_W-1:0] irq_set;
	logic [cio_pkg::IRQ_W-1:0] irq_clr;
	logic [cio_pkg::IRQ_W-1:0] irq_flags;
	logic [cio_pkg::IRQ_W-1:0] irq_en;
	logic                      sel_is_prop;
	logic                      sel_is_copen;
	logic                      next_copen_en;
	logic                      wr_sel;
	logic                      wr_status;

	// ***************************************************
	// ahb-lite slave
	// ***************************************************
	assign accept    = hsel && hready && htrans[1];
	assign wr_sel    = wr_pend && (wr_addr == cio_pkg::REG_SEL);
	assign wr_status = wr_pend && (wr_addr == cio_pkg::REG_STATUS);

	// address phase capture; reads take one wait state so a write just before is seen
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			wr_pend   <= 1'b0;
			wr_addr   <= '0;
			rd_pend   <= 1'b0;
			rd_addr   <= '0;
			hreadyout <= 1'b1;
			hresp     <= cio_pkg::HRESP_OKAY;
			hrdata    <= '0;
		end
		else
		begin
			wr_pend <= accept && hwrite;
			rd_pend <= accept && !hwrite;
			if (accept)
			begin
				wr_addr <= haddr[7:0];
				rd_addr <= haddr[7:0];
			end
			hreadyout <= !(accept && !hwrite);
			if (rd_pend)
				hrdata <= next_rdata;
		end
	end

	// read decode; unmapped offsets read zero with an okay answer
	always_comb
	begin
		next_rdata = '0;
		if (rd_addr == cio_pkg::REG_SEL)
			next_rdata[7:0] = fieldbus_protocol_select;
		else if (rd_addr == cio_pkg::REG_ENABLE)
			next_rdata[0] = fieldbus_protocol_enable;
		else if (rd_addr == cio_pkg::REG_AMODE)
			next_rdata[0] = module_addressing_mode;
		else if (rd_addr == cio_pkg::REG_STATUS)
			next_rdata[cio_pkg::ST_W-1:0] = status_word;
		else if (rd_addr == cio_pkg::REG_PDO)
			next_rdata[15:0] = pdo_cycle_period;
		else if (rd_addr == cio_pkg::REG_CANMODE)
			next_rdata[1:0] = can_mode;
		else if (rd_addr == cio_pkg::REG_IRQ_STAT)
			next_rdata[cio_pkg::IRQ_W-1:0] = irq_flags;
		else if (rd_addr == cio_pkg::REG_IRQ_EN)
			next_rdata[cio_pkg::IRQ_W-1:0] = irq_en;
	end

	// ***************************************************
	// configuration registers
	// ***************************************************
	// nonvolatile select, default 32
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			fieldbus_protocol_select <= cio_pkg::SEL_PROP;
		else if (wr_sel)
			fieldbus_protocol_select <= hwdata[7:0];
		else if (nv_load)
			fieldbus_protocol_select <= nv_protocol_select;
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			module_addressing_mode <= cio_pkg::AMODE_SHARED;
		else if (wr_pend && (wr_addr == cio_pkg::REG_AMODE))
			module_addressing_mode <= hwdata[0];
		else if (nv_load)
			module_addressing_mode <= nv_addressing_mode;
	end

	// store request to the nonvolatile memory after any write of a stored setting
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			nv_save <= 1'b0;
		else
			nv_save <= wr_sel || (wr_pend && (wr_addr == cio_pkg::REG_AMODE));
	end

	assign sel_is_prop  = (fieldbus_protocol_select == cio_pkg::SEL_PROP);
	assign sel_is_copen = (fieldbus_protocol_select >= cio_pkg::SEL_COPEN_LO) &&
	                      (fieldbus_protocol_select <= cio_pkg::SEL_COPEN_HI);

	// protocol enable; a new select reloads its default first
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			fieldbus_protocol_enable <= 1'b1;
		else if (wr_sel)
			fieldbus_protocol_enable <= (hwdata[7:0] == cio_pkg::SEL_PROP);
		else if (nv_load)
			fieldbus_protocol_enable <= (nv_protocol_select == cio_pkg::SEL_PROP);
		else if (sel_is_prop)
			fieldbus_protocol_enable <= 1'b1;
		else if (wr_pend && (wr_addr == cio_pkg::REG_ENABLE))
			fieldbus_protocol_enable <= hwdata[0];
	end

	// pdo period in ms; zero would tick every ms like one in the timer, and it is stored as one
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			pdo_cycle_period <= cio_pkg::PDO_PERIOD_RST;
		else if (wr_pend && (wr_addr == cio_pkg::REG_PDO))
			pdo_cycle_period <= (hwdata[15:0] == '0) ? cio_pkg::PDO_PERIOD_MIN : hwdata[15:0];
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			can_mode <= cio_pkg::CIO_CAN_IO;
		else if (wr_pend && (wr_addr == cio_pkg::REG_CANMODE))
			can_mode <= cio_pkg::cio_can_mode_t'(hwdata[1:0]);
	end

	// ***************************************************
	// protocol routing to the network engine
	// ***************************************************
	assign link_up       = fieldbus_protocol_enable && (can_mode != cio_pkg::CIO_CAN_OFF);
	assign next_copen_en = sel_is_copen && link_up && (can_mode == cio_pkg::CIO_CAN_COPEN);

	// registered enables; mode off silences every protocol
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			prop_io_link_en   <= 1'b0;
			fieldbus_en       <= 1'b0;
			user_proto_en     <= 1'b0;
			canopen_en        <= 1'b0;
			canopen_map       <= '0;
			module_overlap_ok <= 1'b0;
			module_limit      <= '0;
		end
		else
		begin
			prop_io_link_en <= sel_is_prop && link_up && (can_mode == cio_pkg::CIO_CAN_IO);
			fieldbus_en     <= (fieldbus_protocol_select == cio_pkg::SEL_FIELDBUS) && link_up;
			user_proto_en   <= (fieldbus_protocol_select >= cio_pkg::SEL_USER_LO) &&
			                   (fieldbus_protocol_select <= cio_pkg::SEL_USER_HI) && link_up;
			canopen_en      <= next_copen_en;
			canopen_map     <= sel_is_copen ? 2'(fieldbus_protocol_select - cio_pkg::SEL_COPEN_LO) : 2'h0;
			module_overlap_ok <= (module_addressing_mode == cio_pkg::AMODE_SHARED);
			module_limit      <= (module_addressing_mode == cio_pkg::AMODE_SHARED) ?
			                     cio_pkg::MOD_LIMIT_SHARED : cio_pkg::MOD_LIMIT_COMPAT;
		end
	end

	cio_pdo_timer #(
		.STEP_CYCLES (PDO_STEP_CYCLES),
		.PW          (cio_pkg::PDO_PERIOD_W)
	) u_pdo_timer (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.run     (next_copen_en),
		.period  (pdo_cycle_period),
		.tick    (pdo_tx_tick)
	);

	// ***************************************************
	// re-initialisation sequence
	// ***************************************************
	// host request, held until started
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			reinit_req <= 1'b0;
		else if (wr_status && hwdata[cio_pkg::ST_REINIT])
			reinit_req <= 1'b1;
		else if (ri_state == cio_pkg::RI_IDLE)
			reinit_req <= 1'b0;
	end

	// network brought up once after reset, then again on each request
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			ri_state <= cio_pkg::RI_START;
		else
		begin
			case (ri_state)
				cio_pkg::RI_IDLE:
					if (reinit_req)
						ri_state <= cio_pkg::RI_START;
				cio_pkg::RI_START:
					ri_state <= cio_pkg::RI_WAIT;
				cio_pkg::RI_WAIT:
					if (init_done_in)
						ri_state <= cio_pkg::RI_IDLE;
				default:
					ri_state <= cio_pkg::RI_IDLE;
			endcase
		end
	end

	// reinit pulse and completion flag
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			net_reinit    <= 1'b0;
			init_complete <= 1'b0;
		end
		else
		begin
			net_reinit <= (ri_state == cio_pkg::RI_START);
			if ((ri_state == cio_pkg::RI_WAIT) && init_done_in)
				init_complete <= 1'b1;
			else if (ri_state == cio_pkg::RI_START)
				init_complete <= 1'b0;
		end
	end

	// ***************************************************
	// error flags and status word
	// ***************************************************
	genvar g;
	generate
		for (g = 0; g < cio_pkg::GROUP; g++)
		begin : g_err
			if (g < cio_pkg::GROUP - 1)
			begin : g_ilv
				assign err_set[g] = link_up && (module_err[g] || module_err[g + 3] ||
				                    module_err[g + 6] || module_err[g + 9]);
			end
			else
			begin : g_top
				assign err_set[g] = link_up && (|module_err[12 +: cio_pkg::GROUP]);
			end
			assign err_set[cio_pkg::ST_OUT_LO + g] = link_up && (|out_module_err[g*cio_pkg::GROUP +: cio_pkg::GROUP]);
			assign err_set[cio_pkg::ST_IN_LO + g]  = link_up && (|in_module_err[g*cio_pkg::GROUP +: cio_pkg::GROUP]);
		end
	endgenerate

	assign err_set[cio_pkg::ST_REINIT]    = 1'b0;
	assign err_set[cio_pkg::ST_INIT_DONE] = 1'b0;
	assign err_set[cio_pkg::ST_ANALOG]    = link_up && analog_err;
	assign err_clr = {cio_pkg::ST_W{ri_state == cio_pkg::RI_START}};

	cio_sticky_flags #(
		.W (cio_pkg::ST_W)
	) u_err_flags (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.set     (err_set),
		.clr     (err_clr),
		.flags   (err_flags)
	);

	// bit 4 reads back while a reinit is pending or running
	always_comb
	begin
		status_word = err_flags;
		status_word[cio_pkg::ST_REINIT]    = reinit_req || (ri_state != cio_pkg::RI_IDLE);
		status_word[cio_pkg::ST_INIT_DONE] = init_complete;
	end

	// ***************************************************
	// interrupts
	// ***************************************************
	assign irq_set[cio_pkg::IRQ_INIT]    = (ri_state == cio_pkg::RI_WAIT) && init_done_in;
	assign irq_set[cio_pkg::IRQ_MOD_ERR] = |{err_set[cio_pkg::ST_W-1:cio_pkg::ST_OUT_LO], err_set[cio_pkg::GROUP-1:0]};
	assign irq_set[cio_pkg::IRQ_ANALOG]  = err_set[cio_pkg::ST_ANALOG];
	assign irq_clr = (wr_pend && (wr_addr == cio_pkg::REG_IRQ_CLR)) ? hwdata[cio_pkg::IRQ_W-1:0] : '0;

	cio_sticky_flags #(
		.W (cio_pkg::IRQ_W)
	) u_irq_flags (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.set     (irq_set),
		.clr     (irq_clr),
		.flags   (irq_flags)
	);

	// enable mask and level output
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			irq_en <= '0;
			irq    <= 1'b0;
		end
		else
		begin
			if (wr_pend && (wr_addr == cio_pkg::REG_IRQ_EN))
				irq_en <= hwdata[cio_pkg::IRQ_W-1:0];
			irq <= |(irq_flags & irq_en);
		end
	end

endmodule : cio_net_manager

// ---- tb/cio_net_manager_assertions.sv ----
// port checker for the io network manager
// assumes one clock domain and a bus master that keeps ahb-lite order
module cio_net_manager_assertions (
	// clock, reset, bus
	input wire logic        clk_sys,
	input wire logic        resetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	// network side
	input wire logic [7:0]  fieldbus_protocol_select,
	input wire logic        nv_save,
	input wire logic        prop_io_link_en,
	input wire logic        canopen_en,
	input wire logic [1:0]  canopen_map,
	input wire logic        module_overlap_ok,
	input wire logic [5:0]  module_limit,
	input wire logic        net_reinit,
	input wire logic        pdo_tx_tick
);
	timeunit 1ns;
	timeprecision 100ps;
	// ***************************************************
	// properties
	// ***************************************************
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	logic up;
	// limit outputs are only valid from the first edge after reset
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			up <= 1'b0;
		else
			up <= 1'b1;
	end
	sequence s_rd;
		hsel && hready && htrans[1] && !hwrite;
	endsequence
	sequence s_wr_sel;
		hsel && hready && htrans[1] && hwrite && haddr[7:0] == 8'h00;
	endsequence
	sequence s_wr_reinit;
		hsel && hready && htrans[1] && hwrite && haddr[7:0] == 8'h0c ##1 hwdata[4];
	endsequence
	a_read_wait: assert property (s_rd |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	a_sel_write: assert property (s_wr_sel |=> ##1 fieldbus_protocol_select == $past(hwdata[7:0]))
		else $error("select write not taken");
	a_nv_saved: assert property (s_wr_sel |-> ##[2:4] nv_save)
		else $error("select not saved");
	a_reinit_req: assert property (s_wr_reinit |-> ##[1:5] net_reinit)
		else $error("reinit not started");
	a_reinit_pulse: assert property (net_reinit |=> !net_reinit)
		else $error("reinit pulse too long");
	a_prop_sel: assert property (prop_io_link_en |->
		fieldbus_protocol_select == 8'h20 || $past(fieldbus_protocol_select) == 8'h20)
		else $error("proprietary link without select 32");
	a_copen_map: assert property (up && $stable(fieldbus_protocol_select) && canopen_en |->
		canopen_map == 2'(fieldbus_protocol_select - 8'h28))
		else $error("canopen map wrong");
	a_limit_mode: assert property (up |-> module_limit == (module_overlap_ok ? 6'h20 : 6'h10))
		else $error("module limit wrong");
	a_pdo_gap: assert property (pdo_tx_tick |=> !pdo_tx_tick [*8])
		else $error("pdo ticks too close");
	a_pdo_copen: assert property (pdo_tx_tick |-> canopen_en || $past(canopen_en))
		else $error("pdo tick without canopen");
endmodule : cio_net_manager_assertions

bind cio_net_manager cio_net_manager_assertions u_chk (.clk_sys, .resetn, .hsel, .haddr, .htrans, .hwrite,
	.hwdata, .hready, .hreadyout, .fieldbus_protocol_select, .nv_save, .prop_io_link_en, .canopen_en,
	.canopen_map, .module_overlap_ok, .module_limit, .net_reinit, .pdo_tx_tick);

// ---- tb/cio_io_engine_model.sv ----
// remote io engine model: answers reinit with init done, reports faults
// assumes the bench changes its controls just after a clock edge
module cio_io_engine_model (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	// bench control
	input  wire logic        slow,
	input  wire logic        flt,
	input  wire logic [3:0]  flt_idx,
	input  wire logic        flt_ana,
	// manager side
	input  wire logic        net_reinit,
	output logic             init_done_in,
	output logic      [15:0] module_err,
	output logic      [15:0] out_module_err,
	output logic      [15:0] in_module_err,
	output logic             analog_err
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [5:0] cnt;
	// every reinit restarts bring-up; slow mode stretches it
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			cnt <= 6'h0;
		else if (net_reinit)
			cnt <= slow ? 6'h1e : 6'h2;
		else if (cnt != 6'h0)
			cnt <= cnt - 6'h1;
	end
	assign init_done_in = (cnt == 6'h1);
	// one module reports all three fault kinds for one cycle
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			module_err     <= 16'h0;
			out_module_err <= 16'h0;
			in_module_err  <= 16'h0;
			analog_err     <= 1'b0;
		end
		else
		begin
			module_err     <= flt ? 16'h1 << flt_idx : 16'h0;
			out_module_err <= flt ? 16'h1 << flt_idx : 16'h0;
			in_module_err  <= flt ? 16'h1 << flt_idx : 16'h0;
			analog_err     <= flt_ana;
		end
	end
endmodule : cio_io_engine_model

// ---- tb/tb_top.sv ----
// bench for the io network manager: ahb-lite master tasks and directed tests
// assumes a shortened pdo step of 10 cycles
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys, resetn, hsel, hwrite, hready, hreadyout, nv_load, nv_addressing_mode;
	logic prop_io_link_en, fieldbus_en, user_proto_en, canopen_en, module_overlap_ok, net_reinit;
	logic pdo_tx_tick, init_done_in, analog_err, irq, slow, flt, flt_ana, hresp;
	logic [31:0] haddr, hwdata, hrdata, r, e;
	logic [15:0] module_err, out_module_err, in_module_err;
	logic [7:0]  nv_protocol_select;
	logic [5:0]  module_limit;
	logic [3:0]  flt_idx;
	logic [2:0]  hsize;
	logic [1:0]  htrans, canopen_map;
	int          num_errors, tests_run, n;
	assign hready = hreadyout;
	cio_net_manager #(.PDO_STEP_CYCLES(10)) dut (.clk_sys, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready, .hreadyout, .hresp, .hrdata, .nv_load, .nv_protocol_select, .nv_addressing_mode,
		.nv_save(), .fieldbus_protocol_select(), .module_addressing_mode(), .prop_io_link_en, .fieldbus_en,
		.user_proto_en, .canopen_en, .canopen_map, .module_overlap_ok, .module_limit, .net_reinit,
		.pdo_tx_tick, .init_done_in, .module_err, .out_module_err, .in_module_err, .analog_err, .irq);
	cio_io_engine_model u_eng (.clk_sys, .resetn, .slow, .flt, .flt_idx, .flt_ana, .net_reinit,
		.init_done_in, .module_err, .out_module_err, .in_module_err, .analog_err);
	// ***************************************************
	// tasks
	// ***************************************************
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		tests_run++;
		if (got !== ex)
		begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", nm, ex, got);
		end
	endtask : chk
	// one single transfer; caller sits just after a rising edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk_sys); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_sys); while (hready !== 1'b1);
		r = hrdata;
	endtask : xfer
	task automatic rd(input logic [7:0] a, input logic [31:0] ex, input string nm);
		xfer(1'b0, a, 32'h0);
		chk(nm, ex, r);
	endtask : rd
	task automatic settle;
		repeat (3) @(posedge clk_sys);
	endtask : settle
	task automatic wait_init;
		int k;
		k = 0;
		r = 32'h0;
		while (r[5] !== 1'b1 && k < 60)
		begin
			xfer(1'b0, 8'h0c, 32'h0);
			k++;
		end
	endtask : wait_init
	task automatic wait_tick;
		n = 0;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (pdo_tx_tick !== 1'b1 && n < 500);
	endtask : wait_tick
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict
	// ***************************************************
	// clock, watchdog, tests
	// ***************************************************
	initial
	begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	// whole run needs a few hundred cycles
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		num_errors++;
		print_verdict;
	end
	initial
	begin
		{resetn, hsel, hwrite, nv_load, nv_addressing_mode, slow, flt, flt_ana} = 8'h0;
		{haddr, hwdata, htrans, nv_protocol_select, flt_idx} = 78'h0;
		hsize = 3'h2;
		num_errors = 0;
		tests_run = 0;
		repeat (3) @(posedge clk_sys);
		resetn <= 1'b1;
		@(posedge clk_sys);
		rd(8'h00, 32'h20, "select");
		rd(8'h04, 32'h1, "enable");
		rd(8'h08, 32'h0, "addr mode");
		rd(8'h10, 32'h5, "pdo period");
		rd(8'h14, 32'h2, "can mode");
		rd(8'h24, 32'h0, "unmapped");
		chk("okay answer", 32'h0, hresp);
		xfer(1'b1, 8'h04, 32'h0);
		rd(8'h04, 32'h1, "forced enable");
		wait_init;
		rd(8'h0c, 32'h20, "status init");
		rd(8'h18, 32'h1, "irq status init");
		$display("test reset done");
		e = 32'h20;
		for (int i = 0; i < 16; i++)
		begin
			flt_idx <= 4'(i);
			flt <= 1'b1;
			@(posedge clk_sys);
			flt <= 1'b0;
			repeat (2) @(posedge clk_sys);
			e = e | (32'h1 << (i > 11 ? 3 : i % 3)) | (32'h80 << (i / 4)) | (32'h800 << (i / 4));
			rd(8'h0c, e, "status errors");
		end
		flt_ana <= 1'b1;
		@(posedge clk_sys);
		flt_ana <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rd(8'h0c, e | 32'h40, "analog error");
		xfer(1'b1, 8'h20, 32'h2);
		settle;
		chk("irq enabled", 32'h1, irq);
		xfer(1'b1, 8'h20, 32'h0);
		settle;
		chk("irq masked", 32'h0, irq);
		xfer(1'b1, 8'h1c, 32'h2);
		xfer(1'b1, 8'h20, 32'h2);
		settle;
		chk("irq cleared", 32'h0, irq);
		rd(8'h18, 32'h5, "irq status");
		$display("test errors done");
		slow <= 1'b1;
		xfer(1'b1, 8'h0c, 32'h10);
		settle;
		xfer(1'b0, 8'h0c, 32'h0);
		chk("reinit running", 32'h10, r & 32'h30);
		wait_init;
		rd(8'h0c, 32'h20, "status after reinit");
		$display("test reinit done");
		for (int s = 32; s < 43; s++)
		begin
			xfer(1'b1, 8'h00, 32'(s));
			rd(8'h04, 32'(s == 32), "enable default");
			xfer(1'b1, 8'h14, s > 39 ? 32'h3 : 32'h2);
			settle;
			chk("canopen before enable", 32'h0, canopen_en);
			xfer(1'b1, 8'h04, 32'h1);
			settle;
			chk("protocol enables", {s == 32, s == 33, s > 33 && s < 40, s > 39},
				{prop_io_link_en, fieldbus_en, user_proto_en, canopen_en});
			if (s > 39)
				chk("canopen map", 32'(s - 40), canopen_map);
		end
		$display("test select done");
		xfer(1'b1, 8'h10, 32'h2);
		repeat (3) wait_tick;
		chk("pdo gap", 32'd20, n);
		xfer(1'b1, 8'h10, 32'h0);
		rd(8'h10, 32'h1, "pdo minimum");
		xfer(1'b1, 8'h14, 32'h0);
		settle;
		chk("can off", 32'h0, {prop_io_link_en, fieldbus_en, user_proto_en, canopen_en});
		xfer(1'b1, 8'h08, 32'h1);
		settle;
		chk("compat limit", 32'h10, {module_overlap_ok, module_limit});
		xfer(1'b1, 8'h08, 32'h0);
		settle;
		chk("shared limit", 32'h60, {module_overlap_ok, module_limit});
		{nv_protocol_select, nv_addressing_mode, nv_load} <= {8'h21, 2'h3};
		@(posedge clk_sys);
		nv_load <= 1'b0;
		rd(8'h00, 32'h21, "nv select");
		rd(8'h08, 32'h1, "nv mode");
		rd(8'h04, 32'h0, "nv enable");
		$display("test modes done");
		print_verdict;
	end
endmodule : tb_top
